// File: rtl/gpio_ports.sv
// Overview of operation
// R1: Per-bit direction, 0 input, 1 output.
// R2: Output mode drives latch value onto pin.
// R3: Port2 drive type selects push-pull or open-drain.
// R4: Open-drain one floats or is pulled up.
// R5: Port2 pull-up only for input or open-drain.
// R6: Port2 readback: input/open-drain pin, push-pull zero.
// R7: Port2 function bits route serial outputs.
// R8: Port2 input pins feed serial receivers.
// R9: Port4 pull-ups on all bits but six.
// R10: Port4 pull-up needs wakeup or plain input.
// R11: Key wakeup works without function select.
// R12: Port4 function enables analog, bits 5,4 pulses.
// R13: Port4 readback only when direction, function zero.
// R14: Port4 inputs feed stop, trigger, wakeup, analog.
// R15: Port7 inputs feed interrupts and timer inputs.
// R16: Port7 function bits route divider, timer outputs.
// R17: All three ports carry alternate peripheral uses.
// R18: Port7 readback: input pin, output zero.
// R19: Reset clears all latches and controls.
`timescale 1ns/1ps

module gpio_ports
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpio_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port 2 pads
    input wire logic [7:0] port2_pin_in,
    output logic [7:0] port2_pin_out,
    output logic [7:0] port2_pin_oe,
    output logic [7:0] port2_pullup_on,
    // Port 4 pads
    input wire logic [7:0] port4_pin_in,
    output logic [7:0] port4_pin_out,
    output logic [7:0] port4_pin_oe,
    output logic [7:0] port4_pullup_on,
    output logic [7:0] port4_analog_enable,
    // Port 7 pads
    input wire logic [7:0] port7_pin_in,
    output logic [7:0] port7_pin_out,
    output logic [7:0] port7_pin_oe,
    // Serial peripherals
    input wire logic sio_on_port2,
    input wire logic uart2_transmit_out,
    input wire logic uart0_transmit_out,
    input wire logic sync_serial_clock_out,
    input wire logic sync_serial_data_out,
    input wire logic i2c_clock_line_out,
    input wire logic i2c_data_line_out,
    output logic uart2_receive_in,
    output logic uart0_receive_in,
    output logic sync_serial_clock_in,
    output logic sync_serial_data_in,
    output logic i2c_clock_line_in,
    output logic i2c_data_line_in,
    // Key wakeup, analog and ten-bit timer
    input wire logic [7:0] key_wakeup_enable,
    input wire logic ten_bit_pulse_out_a,
    input wire logic ten_bit_pulse_out_b,
    output logic [7:0] key_wakeup_input,
    output logic [7:0] analog_input_line,
    output logic emergency_stop_input,
    output logic ten_bit_timer_trigger_in,
    // Interrupts, divider and timers
    input wire logic divider_output,
    input wire logic wide_timer1_pulse_out,
    input wire logic wide_timer0_pulse_out,
    input wire logic byte_timer1_pulse_out,
    input wire logic byte_timer0_pulse_out,
    output logic ext_interrupt_four,
    output logic ext_interrupt_three,
    output logic ext_interrupt_two,
    output logic wide_timer1_input,
    output logic wide_timer0_input,
    output logic byte_timer1_input,
    output logic byte_timer0_input
);

    function automatic logic reg_hit(input logic [gpio_pkg::ADDR_W-1:0] addr,
                                     input logic [13:0] idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction

    logic [7:0] p2_latch_r, p2_dir_r, p2_func_r, p2_drive_r, p2_pullup_r;
    logic [7:0] p4_latch_r, p4_dir_r, p4_func_r, p4_pullup_r;
    logic [7:0] p7_latch_r, p7_dir_r, p7_func_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;

    logic setup_phase, write_take;
    assign setup_phase = psel & ~penable;
    assign write_take = psel & penable & pready_r & pwrite;

    // Control registers, all cleared by reset [R19]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            p2_latch_r <= gpio_pkg::REG_RESET;
            p2_dir_r <= gpio_pkg::REG_RESET;
            p2_func_r <= gpio_pkg::REG_RESET;
            p2_drive_r <= gpio_pkg::REG_RESET;
            p2_pullup_r <= gpio_pkg::REG_RESET;
        end
        else if (write_take)
        begin
            if (reg_hit(paddr, gpio_pkg::P2_LATCH_IDX))
                p2_latch_r <= pwdata[7:0];
            if (reg_hit(paddr, gpio_pkg::P2_DIR_IDX))
                p2_dir_r <= pwdata[7:0];    // [R1]
            if (reg_hit(paddr, gpio_pkg::P2_FUNC_IDX))
                p2_func_r <= pwdata[7:0];
            if (reg_hit(paddr, gpio_pkg::P2_DRIVE_IDX))
                p2_drive_r <= pwdata[7:0] & gpio_pkg::P2_DRIVE_WMASK;    // [R3]
            if (reg_hit(paddr, gpio_pkg::P2_PULLUP_IDX))
                p2_pullup_r <= pwdata[7:0] & gpio_pkg::P2_PULLUP_WMASK;    // [R5]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            p4_latch_r <= gpio_pkg::REG_RESET;
            p4_dir_r <= gpio_pkg::REG_RESET;
            p4_func_r <= gpio_pkg::REG_RESET;
            p4_pullup_r <= gpio_pkg::REG_RESET;
        end
        else if (write_take)
        begin
            if (reg_hit(paddr, gpio_pkg::P4_LATCH_IDX))
                p4_latch_r <= pwdata[7:0];
            if (reg_hit(paddr, gpio_pkg::P4_DIR_IDX))
                p4_dir_r <= pwdata[7:0];    // [R1]
            if (reg_hit(paddr, gpio_pkg::P4_FUNC_IDX))
                p4_func_r <= pwdata[7:0];
            if (reg_hit(paddr, gpio_pkg::P4_PULLUP_IDX))
                p4_pullup_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            p7_latch_r <= gpio_pkg::REG_RESET;
            p7_dir_r <= gpio_pkg::REG_RESET;
            p7_func_r <= gpio_pkg::REG_RESET;
        end
        else if (write_take)
        begin
            if (reg_hit(paddr, gpio_pkg::P7_LATCH_IDX))
                p7_latch_r <= pwdata[7:0];
            if (reg_hit(paddr, gpio_pkg::P7_DIR_IDX))
                p7_dir_r <= pwdata[7:0];    // [R1]
            if (reg_hit(paddr, gpio_pkg::P7_FUNC_IDX))
                p7_func_r <= pwdata[7:0] & gpio_pkg::P7_FUNC_WMASK;    // [R16]
        end
    end

    // Effective drive type: I2C pins are open-drain whenever they carry I2C
    logic [7:0] p2_odrain, p2_fn_val, p4_fn_val, p7_fn_val;
    assign p2_odrain = p2_drive_r
                     | (p2_func_r & gpio_pkg::P2_I2C_CLK_BIT)
                     | (p2_func_r & gpio_pkg::P2_I2C_DATA_BIT & {8{~sio_on_port2}});    // [R3]

    // Peripheral outputs per pin [R7] [R17]
    assign p2_fn_val = {uart2_transmit_out, uart2_transmit_out, sync_serial_clock_out,
                        i2c_clock_line_out,
                        sio_on_port2 ? sync_serial_data_out : i2c_data_line_out,
                        sync_serial_clock_out, uart0_transmit_out,
                        sio_on_port2 ? sync_serial_data_out : uart0_transmit_out};
    assign p4_fn_val = {2'b00, ten_bit_pulse_out_b, ten_bit_pulse_out_a, 4'h0};    // [R12]
    assign p7_fn_val = {3'b000, divider_output, wide_timer1_pulse_out,
                        wide_timer0_pulse_out, byte_timer1_pulse_out,
                        byte_timer0_pulse_out};    // [R16]

    logic [7:0] p2_val, p2_oe, p4_val, p4_oe, p7_val, p7_oe;

    port_pad_ctrl u_port2
    (
        .latch(p2_latch_r),
        .dir(p2_dir_r),
        .func(p2_func_r),
        .odrain(p2_odrain),
        .func_out_mask(gpio_pkg::P2_FUNC_OUT_MASK),
        .func_value(p2_fn_val),
        .drive_val(p2_val),
        .drive_oe(p2_oe)
    );

    port_pad_ctrl u_port4
    (
        .latch(p4_latch_r),
        .dir(p4_dir_r),
        .func(p4_func_r),
        .odrain(8'h00),
        .func_out_mask(gpio_pkg::P4_FUNC_OUT_MASK),
        .func_value(p4_fn_val),
        .drive_val(p4_val),
        .drive_oe(p4_oe)
    );

    port_pad_ctrl u_port7
    (
        .latch(p7_latch_r),
        .dir(p7_dir_r),
        .func(p7_func_r),
        .odrain(8'h00),
        .func_out_mask(gpio_pkg::P7_FUNC_OUT_MASK),
        .func_value(p7_fn_val),
        .drive_val(p7_val),
        .drive_oe(p7_oe)
    );

    // Input readback views
    logic [7:0] p2_rd, p4_rd, p7_rd, p2_in_mode, p4_in_mode, p7_in_mode;
    assign p2_in_mode = ~p2_dir_r;
    assign p4_in_mode = ~p4_dir_r;
    assign p7_in_mode = ~p7_dir_r;
    assign p2_rd = port2_pin_in & (p2_in_mode | p2_odrain);    // [R6]
    assign p4_rd = port4_pin_in & p4_in_mode & ~p4_func_r;    // [R13]
    assign p7_rd = port7_pin_in & p7_in_mode;    // [R18]

    // Pads, registered so every output comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port2_pin_out <= 8'h00;
            port2_pin_oe <= 8'h00;
            port2_pullup_on <= 8'h00;
            port4_pin_out <= 8'h00;
            port4_pin_oe <= 8'h00;
            port4_pullup_on <= 8'h00;
            port4_analog_enable <= 8'h00;
            port7_pin_out <= 8'h00;
            port7_pin_oe <= 8'h00;
        end
        else
        begin
            port2_pin_out <= p2_val;    // [R2]
            port2_pin_oe <= p2_oe;    // [R4]
            port2_pullup_on <= p2_pullup_r & (p2_in_mode | p2_odrain);    // [R5]
            port4_pin_out <= p4_val;    // [R2]
            port4_pin_oe <= p4_oe;
            port4_pullup_on <= p4_pullup_r & gpio_pkg::P4_PULLUP_PRESENT
                               & (key_wakeup_enable | (p4_in_mode & ~p4_func_r));    // [R9] [R10]
            port4_analog_enable <= p4_func_r;    // [R12]
            port7_pin_out <= p7_val;    // [R2]
            port7_pin_oe <= p7_oe;
        end
    end

    // Receivers idle high when no pin feeds them; the first input pin wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            uart2_receive_in <= 1'b1;
            uart0_receive_in <= 1'b1;
            sync_serial_clock_in <= 1'b1;
            sync_serial_data_in <= 1'b1;
            i2c_clock_line_in <= 1'b1;
            i2c_data_line_in <= 1'b1;
        end
        else
        begin
            uart2_receive_in <= p2_in_mode[7] ? port2_pin_in[7] :
                                p2_in_mode[6] ? port2_pin_in[6] : 1'b1;    // [R8]
            sync_serial_clock_in <= p2_in_mode[5] ? port2_pin_in[5] :
                                    p2_in_mode[2] ? port2_pin_in[2] : 1'b1;    // [R8]
            sync_serial_data_in <= p2_in_mode[4] ? port2_pin_in[4] :
                                   (sio_on_port2 & p2_in_mode[1]) ? port2_pin_in[1] : 1'b1;
            uart0_receive_in <= (~sio_on_port2 & p2_in_mode[1]) ? port2_pin_in[1] :
                                p2_in_mode[0] ? port2_pin_in[0] : 1'b1;    // [R8]
            // Open-drain bus lines are always observed, even while driving low
            i2c_clock_line_in <= port2_pin_in[4];    // [R17]
            i2c_data_line_in <= port2_pin_in[3];
        end
    end

    // Key wakeup sees the pin regardless of function select [R11]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            key_wakeup_input <= 8'h00;
            analog_input_line <= 8'h00;
            emergency_stop_input <= 1'b1;
            ten_bit_timer_trigger_in <= 1'b0;
        end
        else
        begin
            key_wakeup_input <= port4_pin_in;    // [R14]
            analog_input_line <= port4_pin_in & p4_func_r;    // [R12]
            // Stop input is active low, so it idles high when not an input
            emergency_stop_input <= p4_in_mode[7] ? port4_pin_in[7] : 1'b1;    // [R14]
            ten_bit_timer_trigger_in <= port4_pin_in[6] & p4_in_mode[6];    // [R14]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_interrupt_four <= 1'b0;
            ext_interrupt_three <= 1'b0;
            ext_interrupt_two <= 1'b0;
            wide_timer1_input <= 1'b0;
            wide_timer0_input <= 1'b0;
            byte_timer1_input <= 1'b0;
            byte_timer0_input <= 1'b0;
        end
        else
        begin
            ext_interrupt_four <= p7_rd[7];    // [R15]
            ext_interrupt_three <= p7_rd[6];
            ext_interrupt_two <= p7_rd[5];
            wide_timer1_input <= p7_rd[3];    // [R15]
            wide_timer0_input <= p7_rd[2];
            byte_timer1_input <= p7_rd[1];
            byte_timer0_input <= p7_rd[0];
        end
    end

    // APB: data is prepared in the setup cycle, so the access phase has no wait
    logic [7:0] rd_byte;
    logic rd_hit;

    always_comb
    begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        if (reg_hit(paddr, gpio_pkg::P2_LATCH_IDX))
            rd_byte = p2_latch_r;
        else if (reg_hit(paddr, gpio_pkg::P4_LATCH_IDX))
            rd_byte = p4_latch_r;
        else if (reg_hit(paddr, gpio_pkg::P7_LATCH_IDX))
            rd_byte = p7_latch_r;
        else if (reg_hit(paddr, gpio_pkg::P2_INPUT_IDX))
            rd_byte = p2_rd;
        else if (reg_hit(paddr, gpio_pkg::P4_INPUT_IDX))
            rd_byte = p4_rd;
        else if (reg_hit(paddr, gpio_pkg::P7_INPUT_IDX))
            rd_byte = p7_rd;
        else if (reg_hit(paddr, gpio_pkg::P2_DIR_IDX))
            rd_byte = p2_dir_r;
        else if (reg_hit(paddr, gpio_pkg::P4_DIR_IDX))
            rd_byte = p4_dir_r;
        else if (reg_hit(paddr, gpio_pkg::P7_DIR_IDX))
            rd_byte = p7_dir_r;
        else if (reg_hit(paddr, gpio_pkg::P2_PULLUP_IDX))
            rd_byte = p2_pullup_r;
        else if (reg_hit(paddr, gpio_pkg::P4_PULLUP_IDX))
            rd_byte = p4_pullup_r;
        else if (reg_hit(paddr, gpio_pkg::P2_FUNC_IDX))
            rd_byte = p2_func_r;
        else if (reg_hit(paddr, gpio_pkg::P4_FUNC_IDX))
            rd_byte = p4_func_r;
        else if (reg_hit(paddr, gpio_pkg::P7_FUNC_IDX))
            rd_byte = p7_func_r;
        else if (reg_hit(paddr, gpio_pkg::P2_DRIVE_IDX))
            rd_byte = p2_drive_r;
        else
            rd_hit = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata_r <= pwrite ? 32'h0000_0000 : {24'h000000, rd_byte};
            pready_r <= 1'b1;
            pslverr_r <= ~rd_hit;
        end
        else
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

endmodule

// File: common/gpio_pkg.sv
package gpio_pkg;

    // Register indices; the APB byte address is four times the index
    localparam logic [13:0] P2_LATCH_IDX = 14'h0002;
    localparam logic [13:0] P4_LATCH_IDX = 14'h0004;
    localparam logic [13:0] P7_LATCH_IDX = 14'h0007;
    localparam logic [13:0] P2_INPUT_IDX = 14'h000f;
    localparam logic [13:0] P4_INPUT_IDX = 14'h0011;
    localparam logic [13:0] P7_INPUT_IDX = 14'h0014;
    localparam logic [13:0] P2_DIR_IDX = 14'h0f1c;
    localparam logic [13:0] P4_DIR_IDX = 14'h0f1e;
    localparam logic [13:0] P7_DIR_IDX = 14'h0f21;
    localparam logic [13:0] P2_PULLUP_IDX = 14'h0f29;
    localparam logic [13:0] P4_PULLUP_IDX = 14'h0f2b;
    localparam logic [13:0] P2_FUNC_IDX = 14'h0f36;
    localparam logic [13:0] P4_FUNC_IDX = 14'h0f38;
    localparam logic [13:0] P7_FUNC_IDX = 14'h0f3e;
    localparam logic [13:0] P2_DRIVE_IDX = 14'h0f43;

    localparam int ADDR_W = 16;

    // Reset value shared by every control register
    localparam logic [7:0] REG_RESET = 8'h00;

    // Writable bits of the partly read-only registers
    localparam logic [7:0] P2_DRIVE_WMASK = 8'he7;
    localparam logic [7:0] P2_PULLUP_WMASK = 8'he7;
    localparam logic [7:0] P7_FUNC_WMASK = 8'h1f;

    // Port 4 bit 6 has no pull-up device
    localparam logic [7:0] P4_PULLUP_PRESENT = 8'hbf;

    // Bits whose function select routes a digital peripheral output
    localparam logic [7:0] P2_FUNC_OUT_MASK = 8'hff;
    localparam logic [7:0] P4_FUNC_OUT_MASK = 8'h30;
    localparam logic [7:0] P7_FUNC_OUT_MASK = 8'h1f;

    // I2C pins are forced open-drain while their function is on, the data pin only while sio_on_port2 is low
    localparam logic [7:0] P2_I2C_CLK_BIT = 8'h10;
    localparam logic [7:0] P2_I2C_DATA_BIT = 8'h08;

endpackage

// File: rtl/port_pad_ctrl.sv
`timescale 1ns/1ps

// Output path of one eight-bit port: value and enable for each pad
module port_pad_ctrl
(
    // Control state
    input wire logic [7:0] latch,
    input wire logic [7:0] dir,
    input wire logic [7:0] func,
    input wire logic [7:0] odrain,
    // Peripheral side
    input wire logic [7:0] func_out_mask,
    input wire logic [7:0] func_value,
    // Pad side
    output logic [7:0] drive_val,
    output logic [7:0] drive_oe
);

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            // Function bits inside func_out_mask route the peripheral, otherwise the latch
            drive_val[i] = (func[i] & func_out_mask[i]) ? func_value[i] : latch[i];
            // Open drain never drives a one; the pad floats or is pulled up
            drive_oe[i] = dir[i] & ~(odrain[i] & drive_val[i]);
        end
    end

endmodule

// File: dv/gpio_props.sv
`timescale 1ns/1ps

module gpio_props
(
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Pads and peripheral taps
    input wire logic [7:0] port2_pin_in,
    input wire logic [7:0] port2_pin_out,
    input wire logic [7:0] port2_pin_oe,
    input wire logic [7:0] port2_pullup_on,
    input wire logic [7:0] port4_pin_in,
    input wire logic [7:0] port4_pin_oe,
    input wire logic [7:0] port4_pullup_on,
    input wire logic [7:0] port4_analog_enable,
    input wire logic [7:0] port7_pin_in,
    input wire logic [7:0] port7_pin_oe,
    input wire logic [7:0] analog_input_line,
    input wire logic [7:0] key_wakeup_input,
    input wire logic emergency_stop_input,
    input wire logic ext_interrupt_four,
    input wire logic i2c_clock_line_in
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    a_od_high_off: assert property (!(port2_pin_oe & port2_pin_out & port2_pullup_on))
        else $error("pull-up on a pin driven high");
    a_fixed_nopull: assert property ((port2_pullup_on & 8'h18) == 8'h00)
        else $error("pull-up on port2 bit 3 or 4");
    a_bit6_nopull: assert property (!port4_pullup_on[6])
        else $error("pull-up on port4 bit 6");
    a_analog_follow: assert property ($past(presetn) |->
        analog_input_line == ($past(port4_pin_in) & port4_analog_enable))
        else $error("analog line mismatch");
    a_wakeup_follow: assert property ($past(presetn) |->
        key_wakeup_input == $past(port4_pin_in))
        else $error("wakeup line mismatch");
    a_emg_stop: assert property ($past(presetn) |->
        emergency_stop_input == ($past(port4_pin_in[7]) | port4_pin_oe[7]))
        else $error("emergency stop mismatch");
    a_int_four: assert property ($past(presetn) |->
        ext_interrupt_four == ($past(port7_pin_in[7]) & !port7_pin_oe[7]))
        else $error("interrupt four mismatch");
    a_i2c_clk_in: assert property ($past(presetn) |->
        i2c_clock_line_in == $past(port2_pin_in[4]))
        else $error("i2c clock input mismatch");

    c_ready: cover property (pready);
    c_pull: cover property (port2_pullup_on != 8'h00);
    c_int: cover property (ext_interrupt_four);
endmodule

bind gpio_ports gpio_props u_props (.pclk, .presetn, .psel, .penable, .pready, .port2_pin_in,
    .port2_pin_out, .port2_pin_oe, .port2_pullup_on, .port4_pin_in, .port4_pin_oe,
    .port4_pullup_on, .port4_analog_enable, .port7_pin_in, .port7_pin_oe, .analog_input_line,
    .key_wakeup_input, .emergency_stop_input, .ext_interrupt_four, .i2c_clock_line_in);

// File: dv/pad_model.sv
`timescale 1ns/1ps

// Board side of one port: an undriven pin takes the pull-up or the board level
module pad_model
(
    // Pad controls from the block
    input wire logic [7:0] drive_val,
    input wire logic [7:0] drive_oe,
    input wire logic [7:0] pull_on,
    // Board level of an undriven pin
    input wire logic [7:0] board_level,
    // Resolved pin level
    output logic [7:0] level
);
    assign level = (drive_val & drive_oe) | (~drive_oe & (pull_on | board_level));
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps

module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [7:0] port2_pin_in, port2_pin_out, port2_pin_oe, port2_pullup_on, b2, b4, b7;
    logic [7:0] port4_pin_in, port4_pin_out, port4_pin_oe, port4_pullup_on, port4_analog_enable;
    logic [7:0] port7_pin_in, port7_pin_out, port7_pin_oe, key_wakeup_enable, key_wakeup_input;
    logic [7:0] analog_input_line;
    logic sio_on_port2, uart2_transmit_out, uart0_transmit_out, sync_serial_clock_out;
    logic sync_serial_data_out, i2c_clock_line_out, i2c_data_line_out, uart2_receive_in;
    logic uart0_receive_in, sync_serial_clock_in, sync_serial_data_in, i2c_clock_line_in;
    logic i2c_data_line_in, ten_bit_pulse_out_a, ten_bit_pulse_out_b, emergency_stop_input;
    logic ten_bit_timer_trigger_in, divider_output, wide_timer1_pulse_out, wide_timer0_pulse_out;
    logic byte_timer1_pulse_out, byte_timer0_pulse_out, ext_interrupt_four, ext_interrupt_three;
    logic ext_interrupt_two, wide_timer1_input, wide_timer0_input, byte_timer1_input;
    logic byte_timer0_input;
    logic [13:0] idx_tab [12];
    logic [7:0] msk_tab [12];
    int err_total, total_checks, cyc;

    gpio_ports u_dut (.*);
    pad_model u_pad2 (.drive_val(port2_pin_out), .drive_oe(port2_pin_oe),
        .pull_on(port2_pullup_on), .board_level(b2), .level(port2_pin_in));
    pad_model u_pad4 (.drive_val(port4_pin_out), .drive_oe(port4_pin_oe),
        .pull_on(port4_pullup_on), .board_level(b4), .level(port4_pin_in));
    pad_model u_pad7 (.drive_val(port7_pin_out), .drive_oe(port7_pin_oe),
        .pull_on(8'h00), .board_level(b7), .level(port7_pin_in));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // A hung handshake ends here rather than stalling the run
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total = err_total + 1;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic [13:0] idx, input logic wr_en, input logic [7:0] wd,
                       output logic [31:0] rdat, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] v);
        apb(idx, 1'b1, v, d, e);
        chk("write error", 0, e);
    endtask

    task automatic rd(input logic [13:0] idx, input logic [7:0] exp, input string nm);
        apb(idx, 1'b0, 8'h00, d, e);
        chk(nm, {24'h0, exp}, d);
        chk("read error", 0, e);
    endtask

    // Pads follow a register write one clock later; three edges leave margin
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic p2_case(input logic [7:0] dir, lat, od, pu);
        logic [7:0] odm, oe, pe, lvl;
        wr(gpio_pkg::P2_DIR_IDX, dir);
        wr(gpio_pkg::P2_LATCH_IDX, lat);
        wr(gpio_pkg::P2_DRIVE_IDX, od);
        wr(gpio_pkg::P2_PULLUP_IDX, pu);
        settle();
        odm = od & gpio_pkg::P2_DRIVE_WMASK & dir;
        oe = dir & ~(odm & lat);
        pe = pu & gpio_pkg::P2_PULLUP_WMASK & (~dir | odm);
        lvl = (lat & oe) | (~oe & (pe | b2));
        chk("port2 enable", oe, port2_pin_oe);
        chk("port2 drive", lat & oe, port2_pin_out & oe);
        chk("port2 pull", pe, port2_pullup_on);
        rd(gpio_pkg::P2_INPUT_IDX, lvl & (~dir | odm), "port2 input");
    endtask

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, key_wakeup_enable} = '0;
        {sio_on_port2, uart2_transmit_out, uart0_transmit_out, sync_serial_clock_out,
            sync_serial_data_out, i2c_clock_line_out, i2c_data_line_out, ten_bit_pulse_out_a,
            ten_bit_pulse_out_b, divider_output, wide_timer1_pulse_out, wide_timer0_pulse_out,
            byte_timer1_pulse_out, byte_timer0_pulse_out} = '0;
        b2 = 8'h3c;
        b4 = 8'ha5;
        b7 = 8'hda;
        err_total = 0;
        total_checks = 0;
        cyc = 0;
        idx_tab = '{gpio_pkg::P2_LATCH_IDX, gpio_pkg::P4_LATCH_IDX, gpio_pkg::P7_LATCH_IDX,
            gpio_pkg::P2_DIR_IDX, gpio_pkg::P4_DIR_IDX, gpio_pkg::P7_DIR_IDX,
            gpio_pkg::P2_PULLUP_IDX, gpio_pkg::P4_PULLUP_IDX, gpio_pkg::P2_FUNC_IDX,
            gpio_pkg::P4_FUNC_IDX, gpio_pkg::P7_FUNC_IDX, gpio_pkg::P2_DRIVE_IDX};
        msk_tab = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'he7, 8'hff, 8'hff, 8'hff,
            8'h1f, 8'he7};
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 12; i++)
            rd(idx_tab[i], 8'h00, "reset value");
        for (int i = 0; i < 12; i++)
        begin
            wr(idx_tab[i], 8'hff);
            rd(idx_tab[i], msk_tab[i], "read back");
            wr(idx_tab[i], 8'h00);
        end
        apb(14'h0003, 1'b1, 8'hff, d, e);
        chk("error flag", 1, e);
        apb(14'h0003, 1'b0, 8'h00, d, e);
        chk("unmapped data", 0, d);
        chk("error flag", 1, e);
        p2_case(8'h00, 8'h00, 8'h00, 8'h00);
        p2_case(8'hff, 8'ha5, 8'h00, 8'hff);
        p2_case(8'hff, 8'ha5, 8'hff, 8'hff);
        p2_case(8'h0f, 8'hff, 8'hf0, 8'hff);
        wr(gpio_pkg::P2_PULLUP_IDX, 8'h00);
        wr(gpio_pkg::P2_DRIVE_IDX, 8'h00);
        wr(gpio_pkg::P2_DIR_IDX, 8'h90);
        wr(gpio_pkg::P2_FUNC_IDX, 8'h90);
        {sio_on_port2, uart2_transmit_out, i2c_clock_line_out} <= 3'b101;
        settle();
        chk("fn pins", 3'b100, {port2_pin_oe[7], port2_pin_out[7], port2_pin_oe[4]});
        chk("serial in", {b2[6], b2[0], b2[1]}, {uart2_receive_in, uart0_receive_in,
            sync_serial_data_in});
        wr(gpio_pkg::P2_FUNC_IDX, 8'h00);
        wr(gpio_pkg::P4_DIR_IDX, 8'h0f);
        wr(gpio_pkg::P4_FUNC_IDX, 8'h30);
        wr(gpio_pkg::P4_PULLUP_IDX, 8'hff);
        settle();
        chk("analog enable", 8'h30, port4_analog_enable);
        chk("port4 pull", 8'h80, port4_pullup_on);
        rd(gpio_pkg::P4_INPUT_IDX, 8'h80, "port4 input");
        key_wakeup_enable <= 8'hff;
        settle();
        chk("port4 wake pull", 8'hbf, port4_pullup_on);
        chk("wakeup input", 8'hb0, key_wakeup_input);
        chk("analog line", 8'h30, analog_input_line);
        wr(gpio_pkg::P4_DIR_IDX, 8'h3f);
        ten_bit_pulse_out_a <= 1'b1;
        settle();
        chk("port4 pulse", 8'h10, port4_pin_out & port4_pin_oe & 8'h30);
        wr(gpio_pkg::P7_DIR_IDX, 8'h0f);
        settle();
        rd(gpio_pkg::P7_INPUT_IDX, 8'hd0, "port7 input");
        chk("interrupt three", 1, ext_interrupt_three);
        wr(gpio_pkg::P7_DIR_IDX, 8'h1f);
        wr(gpio_pkg::P7_FUNC_IDX, 8'h1f);
        {divider_output, wide_timer1_pulse_out, wide_timer0_pulse_out, byte_timer1_pulse_out,
            byte_timer0_pulse_out} <= 5'b10101;
        settle();
        chk("port7 outputs", 8'h15, port7_pin_out & port7_pin_oe);
        end_sim();
    end
endmodule
